// [awt_pkg.sv]
// ==========================================================================
// Shared constants for the window threshold register block
package awt_pkg;
  // ========================================================================
  // Bus geometry
  localparam int ADR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;

  // ========================================================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ACC_CTRL = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_TEMP = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_RES_LO = 6'h10;
  localparam logic [IDX_W-1:0] IDX_LT_LO = 6'h12;
  localparam logic [IDX_W-1:0] IDX_HT_LO = 6'h14;
  localparam logic [IDX_W-1:0] IDX_CONVERTER_CALIBRATION = 6'h16;
  localparam logic [IDX_W-1:0] HI_BYTE_OFS = 6'h01;
  localparam logic [IDX_W-1:0] IDX_RES_HI = IDX_RES_LO + HI_BYTE_OFS;
  localparam logic [IDX_W-1:0] IDX_LT_HI = IDX_LT_LO + HI_BYTE_OFS;
  localparam logic [IDX_W-1:0] IDX_HT_HI = IDX_HT_LO + HI_BYTE_OFS;

  // ========================================================================
  // Field layouts and reset values
  localparam int RES_W = 10;
  localparam int SUM_W = 16;
  localparam int CNT_W = 7;
  localparam int LOG2_W = 3;
  localparam int DUTY_BIT = 0;
  localparam logic [7:0] CONVERTER_CALIBRATION_RST = 8'h01;
  localparam logic [7:0] CONVERTER_CALIBRATION_RW_MASK = 8'h07;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [SUM_W-1:0] THR_RST = 16'h0000;
  localparam logic [SUM_W-1:0] RES_RST = 16'h0000;
  localparam logic [LOG2_W-1:0] ACC_LOG2_RST = 3'h0;
  localparam logic [LOG2_W-1:0] ACC_LOG2_MAX = 3'h6;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // ========================================================================
  // Timing: converter clock divider sized so that 25 percent duty stays legal
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int DUTY_LIMIT_KHZ = 1500;
  localparam int MIN_DIV = (CLK_FREQ_KHZ + DUTY_LIMIT_KHZ - 1) / DUTY_LIMIT_KHZ;
  localparam int CONV_DIV = ((MIN_DIV + 3) / 4) * 4;
endpackage

// [awt_core_if.sv]
`timescale 1ns/1ns
// ==========================================================================
// Carrier between the register file, the comparator and the clock divider
interface awt_core_if;
  logic [awt_pkg::SUM_W-1:0] result;
  logic [awt_pkg::SUM_W-1:0] low_thr;
  logic [awt_pkg::SUM_W-1:0] high_thr;
  logic check;
  logic below;
  logic above;
  logic duty;
  logic conv_clk;
  modport regs (output result, output low_thr, output high_thr, output check,
                output duty, input below, input above, input conv_clk);
  modport cmp (input result, input low_thr, input high_thr, input check,
               output below, output above);
  modport cgen (input duty, output conv_clk);
endinterface

// [awt_window_cmp.sv]
`timescale 1ns/1ns
// ==========================================================================
// Digital window comparator, unsigned magnitude compare
module awt_window_cmp
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  awt_core_if.cmp bus // Result and thresholds in, flags out
);
  // Flags refresh only on a finished result, so partial sums never trip them
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bus.below <= 1'b0;
      bus.above <= 1'b0;
    end
    else if (bus.check)
    begin
      bus.below <= (bus.result < bus.low_thr); // RULE4
      bus.above <= (bus.result > bus.high_thr); // RULE1
    end
  end

  // ========================================================================
  // Checks
  a_below_flag: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    bus.check |=> bus.below == ($past(bus.result) < $past(bus.low_thr)))
    else $error("below flag does not match unsigned compare");
  a_flags_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    !bus.check |=> $stable(bus.above) && $stable(bus.below))
    else $error("flags changed without a finished result");
endmodule

// [awt_conv_clk.sv]
`timescale 1ns/1ns
// ==========================================================================
// Converter clock divider with selectable high phase
module awt_conv_clk
#(
  parameter int DIV = awt_pkg::CONV_DIV // System clocks per converter clock
)
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  awt_core_if.cgen bus // Duty select in, converter clock out
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] QTR = CW'(DIV / 4);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2);
  logic [CW-1:0] cnt_r;
  logic duty_lat_r;
  logic clk_r;
  logic [CW-1:0] hi_len_r;

  // Phase counter; duty is taken only at a period end to avoid runt pulses
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      duty_lat_r <= awt_pkg::CONVERTER_CALIBRATION_RST[awt_pkg::DUTY_BIT];
    end
    else if (cnt_r == LAST)
    begin
      cnt_r <= '0;
      duty_lat_r <= bus.duty;
    end
    else
      cnt_r <= cnt_r + CW'(1);
  end

  // Select 1 gives a quarter high phase, 0 gives half
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      clk_r <= 1'b0;
    else
      clk_r <= (cnt_r < (duty_lat_r ? QTR : HALF)); // RULE7
  end

  assign bus.conv_clk = clk_r;

  // ========================================================================
  // Checks
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      hi_len_r <= '0;
    else
      hi_len_r <= clk_r ? hi_len_r + CW'(1) : '0;
  end
  a_duty_high_len: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    $fell(clk_r) |-> hi_len_r == (duty_lat_r ? QTR : HALF))
    else $error("converter clock high phase has wrong length");
endmodule

// [awt_regs.sv]
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
// ==========================================================================
// Window threshold and calibration registers behind a Wishbone slave
// Notes on behaviour
// RULE1: Read/write 16-bit high threshold, reset zero, upper bound for the comparator.
// RULE2: Each 16-bit threshold splits into low byte at base, high byte at base+1.
// RULE3: Converter sample is 10 bits in result bits 9..0, bit 9 most significant.
// RULE4: Results and thresholds are unsigned magnitudes, compared as plain unsigned.
// RULE5: Low threshold has high byte 15:8, low byte 7:0, all read/write, reset zero.
// RULE6: Calibration resets to 0x01, bit 0 selects duty, bits 2:1 read/write.
// RULE7: Duty 0 gives 50 percent, 1 gives 25 percent high; software picks per rate.
// RULE8: When accumulating, the comparator checks the accumulated sum, not each sample.
// RULE9: One shared temporary byte carries 16-bit accesses across two byte accesses.
module awt_regs
#(
  parameter int CONV_DIV = awt_pkg::CONV_DIV // System clocks per converter clock
)
(
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [awt_pkg::ADR_W-1:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [awt_pkg::DATA_W-1:0] wb_dat_i, // Wishbone write data
  output logic [awt_pkg::DATA_W-1:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic sample_valid_i, // Converter sample strobe
  input wire logic [awt_pkg::RES_W-1:0] sample_data_i, // Converter sample value
  output logic conv_clk_o, // Converter clock
  output logic below_low_o, // Result below low threshold
  output logic above_high_o // Result above high threshold
);
  // ========================================================================
  // Declarations
  awt_core_if core_bus ();
  logic ack_r;
  logic [awt_pkg::DATA_W-1:0] rdata_r;
  logic [7:0] temp_r;
  logic [awt_pkg::SUM_W-1:0] thr_low_r;
  logic [awt_pkg::SUM_W-1:0] thr_high_r;
  logic [7:0] converter_calibration_r;
  logic [awt_pkg::LOG2_W-1:0] acc_log2_r;
  logic [awt_pkg::SUM_W-1:0] acc_sum_r;
  logic [awt_pkg::CNT_W-1:0] acc_cnt_r;
  logic [awt_pkg::SUM_W-1:0] result_r;
  logic check_r;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [awt_pkg::IDX_W-1:0] idx;
  logic [7:0] wbyte;
  logic [awt_pkg::SUM_W-1:0] sum_nxt;
  logic [awt_pkg::CNT_W-1:0] cnt_nxt;
  logic [awt_pkg::CNT_W-1:0] acc_target;
  logic [7:0] rbyte_nxt;
  logic [awt_pkg::LOG2_W-1:0] log2_nxt;

  // ========================================================================
  // Bus decode
  // One access per strobe: the cycle that raises ack is blocked from a second
  always_comb
  begin
    access = wb_cyc_i && wb_stb_i && !ack_r;
    wr_en = access && wb_we_i && wb_sel_i[0];
    rd_en = access && !wb_we_i;
    idx = wb_adr_i[awt_pkg::ADR_W-1:2];
    wbyte = wb_dat_i[7:0];
  end

  // Acknowledge one cycle after the request, also for unmapped addresses
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ack_r <= 1'b0;
    else
      ack_r <= access;
  end

  // Read mux; high bytes of 16-bit pairs come from the shared temporary byte
  always_comb
  begin
    unique case (idx)
      awt_pkg::IDX_TEMP: rbyte_nxt = temp_r;
      awt_pkg::IDX_RES_LO: rbyte_nxt = result_r[7:0];
      awt_pkg::IDX_LT_LO: rbyte_nxt = thr_low_r[7:0]; // RULE5
      awt_pkg::IDX_HT_LO: rbyte_nxt = thr_high_r[7:0]; // RULE2
      awt_pkg::IDX_RES_HI,
      awt_pkg::IDX_LT_HI,
      awt_pkg::IDX_HT_HI: rbyte_nxt = temp_r; // RULE9
      awt_pkg::IDX_CONVERTER_CALIBRATION: rbyte_nxt = converter_calibration_r;
      awt_pkg::IDX_ACC_CTRL: rbyte_nxt = {5'h00, acc_log2_r};
      default: rbyte_nxt = 8'h00;
    endcase
  end

  // Read data register; narrow data sits in the low byte, upper bits zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_r <= awt_pkg::RD_ZERO;
    else if (rd_en)
      rdata_r <= {24'h00_0000, rbyte_nxt};
  end

  // ========================================================================
  // Shared temporary byte
  // Low byte write parks data here; low byte read parks the high byte here
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      temp_r <= awt_pkg::TEMP_RST;
    else if (wr_en && (idx == awt_pkg::IDX_TEMP || idx == awt_pkg::IDX_LT_LO ||
                       idx == awt_pkg::IDX_HT_LO))
      temp_r <= wbyte; // RULE9
    else if (rd_en && idx == awt_pkg::IDX_RES_LO)
      temp_r <= result_r[15:8]; // RULE9
    else if (rd_en && idx == awt_pkg::IDX_LT_LO)
      temp_r <= thr_low_r[15:8]; // RULE9
    else if (rd_en && idx == awt_pkg::IDX_HT_LO)
      temp_r <= thr_high_r[15:8]; // RULE9
  end

  // ========================================================================
  // Threshold registers
  // Only the high byte write commits, so both halves change in one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      thr_low_r <= awt_pkg::THR_RST;
    else if (wr_en && idx == awt_pkg::IDX_LT_HI)
      thr_low_r <= {wbyte, temp_r}; // RULE5
  end

  // Upper bound of the window
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      thr_high_r <= awt_pkg::THR_RST;
    else if (wr_en && idx == awt_pkg::IDX_HT_HI)
      thr_high_r <= {wbyte, temp_r}; // RULE1
  end

  // ========================================================================
  // Calibration and accumulation control
  // Bits above 2 are not stored and read back as zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      converter_calibration_r <= awt_pkg::CONVERTER_CALIBRATION_RST;
    else if (wr_en && idx == awt_pkg::IDX_CONVERTER_CALIBRATION)
      converter_calibration_r <= wbyte & awt_pkg::CONVERTER_CALIBRATION_RW_MASK; // RULE6
  end

  // Sample count as a power of two, clamped so the sum cannot overflow
  always_comb
  begin
    if (wbyte[awt_pkg::LOG2_W-1:0] > awt_pkg::ACC_LOG2_MAX)
      log2_nxt = awt_pkg::ACC_LOG2_MAX;
    else
      log2_nxt = wbyte[awt_pkg::LOG2_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      acc_log2_r <= awt_pkg::ACC_LOG2_RST;
    else if (wr_en && idx == awt_pkg::IDX_ACC_CTRL)
      acc_log2_r <= log2_nxt;
  end

  // ========================================================================
  // Result accumulation
  always_comb
  begin
    sum_nxt = acc_sum_r + awt_pkg::SUM_W'(sample_data_i); // RULE3
    cnt_nxt = acc_cnt_r + awt_pkg::CNT_W'(1);
    acc_target = awt_pkg::CNT_W'(1) << acc_log2_r;
  end

  // A new sample count restarts the run, so no sum mixes two settings
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      acc_sum_r <= awt_pkg::RES_RST;
      acc_cnt_r <= '0;
    end
    else if (wr_en && idx == awt_pkg::IDX_ACC_CTRL)
    begin
      acc_sum_r <= awt_pkg::RES_RST;
      acc_cnt_r <= '0;
    end
    else if (sample_valid_i && cnt_nxt == acc_target)
    begin
      acc_sum_r <= awt_pkg::RES_RST;
      acc_cnt_r <= '0;
    end
    else if (sample_valid_i)
    begin
      acc_sum_r <= sum_nxt;
      acc_cnt_r <= cnt_nxt;
    end
  end

  // Finished sum lands in the result and triggers one comparison
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      result_r <= awt_pkg::RES_RST;
      check_r <= 1'b0;
    end
    else
    begin
      check_r <= sample_valid_i && cnt_nxt == acc_target &&
                 !(wr_en && idx == awt_pkg::IDX_ACC_CTRL); // RULE8
      if (sample_valid_i && cnt_nxt == acc_target &&
          !(wr_en && idx == awt_pkg::IDX_ACC_CTRL))
        result_r <= sum_nxt; // RULE8
    end
  end

  // ========================================================================
  // Comparator and converter clock
  assign core_bus.result = result_r;
  assign core_bus.low_thr = thr_low_r;
  assign core_bus.high_thr = thr_high_r;
  assign core_bus.check = check_r;
  assign core_bus.duty = converter_calibration_r[awt_pkg::DUTY_BIT]; // RULE7

  awt_window_cmp u_cmp
  (
    .clk(clk),
    .rst_b(rst_b),
    .bus(core_bus)
  );

  awt_conv_clk #(.DIV(CONV_DIV)) u_conv_clk
  (
    .clk(clk),
    .rst_b(rst_b),
    .bus(core_bus)
  );

  // All outputs are flops here or inside the two leaves
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign conv_clk_o = core_bus.conv_clk;
  assign below_low_o = core_bus.below;
  assign above_high_o = core_bus.above;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_ht_lo_wr;
    wr_en && idx == awt_pkg::IDX_HT_LO;
  endsequence
  sequence s_ht_hi_wr;
    wr_en && idx == awt_pkg::IDX_HT_HI;
  endsequence
  // Writes that commit straight into a stored register
  sequence s_lt_hi_wr;
    wr_en && idx == awt_pkg::IDX_LT_HI;
  endsequence
  sequence s_converter_calibration_wr;
    wr_en && idx == awt_pkg::IDX_CONVERTER_CALIBRATION;
  endsequence

  a_low_byte_parks: assert property (s_ht_lo_wr |=> // RULE2
    $stable(thr_high_r) && temp_r == $past(wb_dat_i[7:0]))
    else $error("low byte write did not park in temporary byte");
  a_pair_commit: assert property (s_ht_lo_wr ##3 s_ht_hi_wr |=> // RULE9
    thr_high_r == {$past(wb_dat_i[7:0]), $past(wb_dat_i[7:0], 4)})
    else $error("16-bit threshold write did not commit both bytes");
  a_high_write: assert property (s_ht_hi_wr |=> // RULE1
    thr_high_r == {$past(wb_dat_i[7:0]), $past(temp_r)})
    else $error("high threshold high byte write wrong");
  a_reset_values: assert property (disable iff (1'b0) // RULE5
    !rst_b |=> thr_low_r == awt_pkg::THR_RST && thr_high_r == awt_pkg::THR_RST &&
    converter_calibration_r == awt_pkg::CONVERTER_CALIBRATION_RST)
    else $error("register reset values wrong");
  a_converter_calibration_upper: assert property (converter_calibration_r[7:3] == 5'h00) // RULE6
    else $error("calibration unused bits set");
  a_single_sample: assert property (sample_valid_i && acc_log2_r == 3'h0 && // RULE3
    !wr_en |=> result_r == {6'h00, $past(sample_data_i)} && check_r)
    else $error("single sample result wrong");
  a_ack_one_cycle: assert property ($rose(wb_ack_o) |=> !wb_ack_o) // RULE2
    else $error("acknowledge longer than one cycle");
  a_read_high_temp: assert property (rd_en && idx == awt_pkg::IDX_LT_HI |=> // RULE9
    wb_dat_o == {24'h00_0000, $past(temp_r)})
    else $error("high byte read did not return temporary byte");
  a_low_commit: assert property (s_lt_hi_wr |=> // RULE5
    thr_low_r == {$past(wb_dat_i[7:0]), $past(temp_r)})
    else $error("low threshold high byte write wrong");
  a_converter_calibration_write: assert property (s_converter_calibration_wr |=> // RULE6
    converter_calibration_r == ($past(wb_dat_i[7:0]) & awt_pkg::CONVERTER_CALIBRATION_RW_MASK))
    else $error("calibration write did not store bits 2:0");
  a_no_partial_check: assert property (sample_valid_i && cnt_nxt != acc_target |=> // RULE8
    !check_r && $stable(result_r))
    else $error("comparison fired before the sum was complete");
endmodule

// [awt_regs_unused_marker.sv]
`timescale 1ns/1ns

// [testbench.sv]
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench for the window threshold register block
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end

module testbench;
  // ========================================================================
  // Stimulus signals, all given a value at time zero
  localparam int DIV = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic sample_valid_i = 1'b0;
  logic [9:0] sample_data_i = 10'h000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic conv_clk_o;
  logic below_low_o;
  logic above_high_o;
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic [9:0] smp [4] = '{10'h0ff, 10'h300, 10'h200, 10'h100};
  logic [1:0] flg [4] = '{2'b10, 2'b01, 2'b00, 2'b00};

  // Clock: 250 MHz
  always #2 clk = ~clk;

  // Short converter clock period keeps the duty measurement brief
  awt_regs #(.CONV_DIV(DIV)) uut
  (
    .clk(clk), // System clock
    .rst_b(rst_b), // Reset
    .wb_cyc_i(wb_cyc_i), // Cycle
    .wb_stb_i(wb_stb_i), // Strobe
    .wb_we_i(wb_we_i), // Direction
    .wb_adr_i(wb_adr_i), // Address
    .wb_sel_i(wb_sel_i), // Byte selects
    .wb_dat_i(wb_dat_i), // Write data
    .wb_dat_o(wb_dat_o), // Read data
    .wb_ack_o(wb_ack_o), // Acknowledge
    .sample_valid_i(sample_valid_i), // Sample strobe
    .sample_data_i(sample_data_i), // Sample value
    .conv_clk_o(conv_clk_o), // Converter clock
    .below_low_o(below_low_o), // Below flag
    .above_high_o(above_high_o) // Above flag
  );

  // ========================================================================
  // Verdict, the single place where the run ends
  task close_out;
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One classic cycle; waits for ack under a bound, then idles a cycle
  task wb_xfer(input logic w, input logic [5:0] idx, input logic [3:0] s,
               input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    `CHK("wb ack", 1'b1, wb_ack_o)
    // A slave that never answers ends the run here
    if (wb_ack_o !== 1'b1)
      close_out();
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, idx, 4'h1, d, r);
  endtask

  // Read data upper bits must come back zero as well
  task rd_chk(input string nm, input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] r;
    wb_xfer(1'b0, idx, 4'h1, 8'h00, r);
    `CHK(nm, {24'h00_0000, e}, r)
  endtask

  // Back-to-back samples, then wait until flags have settled
  task samp(input logic [9:0] d, input int k);
    repeat (k)
    begin
      sample_valid_i <= 1'b1;
      sample_data_i <= d;
      @(posedge clk);
    end
    sample_valid_i <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Counts the high phase of one converter clock period
  task duty_chk(input int e);
    int n;
    int h;
    n = 0;
    h = 0;
    @(posedge clk);
    while (conv_clk_o !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    while (conv_clk_o !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    while (conv_clk_o === 1'b1 && h < 40)
    begin
      @(posedge clk);
      h++;
    end
    `CHK("conv clk high cycles", e, h)
  endtask

  // ========================================================================
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #40000;
    n_fail++;
    close_out();
  end

  // ========================================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset values
    rd_chk("low thr lo", awt_pkg::IDX_LT_LO, 8'h00);
    rd_chk("low thr hi", awt_pkg::IDX_LT_HI, 8'h00);
    rd_chk("high thr lo", awt_pkg::IDX_HT_LO, 8'h00);
    rd_chk("high thr hi", awt_pkg::IDX_HT_HI, 8'h00);
    rd_chk("converter_calibration", awt_pkg::IDX_CONVERTER_CALIBRATION, 8'h01);
    duty_chk(DIV / 4);
    // Low byte parks in the shared temp until the high byte commits
    wr(awt_pkg::IDX_LT_LO, 8'h5a);
    rd_chk("temp after lo write", awt_pkg::IDX_TEMP, 8'h5a);
    rd_chk("low thr lo uncommitted", awt_pkg::IDX_LT_LO, 8'h00);
    wr(awt_pkg::IDX_LT_LO, 8'h00);
    wr(awt_pkg::IDX_LT_HI, 8'h01);
    wr(awt_pkg::IDX_HT_LO, 8'h00);
    wr(awt_pkg::IDX_HT_HI, 8'h02);
    rd_chk("low thr lo", awt_pkg::IDX_LT_LO, 8'h00);
    rd_chk("temp after lo read", awt_pkg::IDX_TEMP, 8'h01);
    rd_chk("low thr hi", awt_pkg::IDX_LT_HI, 8'h01);
    rd_chk("high thr hi", awt_pkg::IDX_HT_HI, 8'h01);
    rd_chk("high thr lo", awt_pkg::IDX_HT_LO, 8'h00);
    rd_chk("high thr hi", awt_pkg::IDX_HT_HI, 8'h02);
    // A write without byte lane 0 must leave the register alone
    wb_xfer(1'b1, awt_pkg::IDX_CONVERTER_CALIBRATION, 4'he, 8'h00, q);
    rd_chk("converter_calibration masked write", awt_pkg::IDX_CONVERTER_CALIBRATION, 8'h01);
    rd_chk("unmapped", 6'h3f, 8'h00);
    // Calibration: only bits 2:0 hold, duty follows bit 0
    wr(awt_pkg::IDX_CONVERTER_CALIBRATION, 8'h06);
    rd_chk("converter_calibration", awt_pkg::IDX_CONVERTER_CALIBRATION, 8'h06);
    repeat (2 * DIV) @(posedge clk);
    duty_chk(DIV / 2);
    wr(awt_pkg::IDX_CONVERTER_CALIBRATION, 8'hff);
    rd_chk("converter_calibration", awt_pkg::IDX_CONVERTER_CALIBRATION, 8'h07);
    repeat (2 * DIV) @(posedge clk);
    duty_chk(DIV / 4);
    // Single samples against low 0x0100, high 0x0200, strict compare
    for (int i = 0; i < 4; i++)
    begin
      samp(smp[i], 1);
      `CHK("flags", flg[i], {below_low_o, above_high_o})
      rd_chk("result lo", awt_pkg::IDX_RES_LO, smp[i][7:0]);
      rd_chk("result hi", awt_pkg::IDX_RES_HI, {6'h00, smp[i][9:8]});
    end
    // Accumulate four full-scale samples; flags only move on the sum
    wr(awt_pkg::IDX_ACC_CTRL, 8'h07);
    rd_chk("acc ctrl clamp", awt_pkg::IDX_ACC_CTRL, 8'h06);
    wr(awt_pkg::IDX_ACC_CTRL, 8'h02);
    samp(10'h3ff, 3);
    `CHK("above mid run", 1'b0, above_high_o)
    samp(10'h3ff, 1);
    `CHK("above on sum", 1'b1, above_high_o)
    rd_chk("sum lo", awt_pkg::IDX_RES_LO, 8'hfc);
    rd_chk("sum hi", awt_pkg::IDX_RES_HI, 8'h0f);
    // A 64-sample full-scale sum has its top bit set, so a signed compare would flip both flags
    wr(awt_pkg::IDX_ACC_CTRL, 8'h06);
    samp(10'h3ff, 64);
    `CHK("above on full scale", 1'b1, above_high_o)
    `CHK("below on full scale", 1'b0, below_low_o)
    rd_chk("full sum lo", awt_pkg::IDX_RES_LO, 8'hc0);
    rd_chk("full sum hi", awt_pkg::IDX_RES_HI, 8'hff);
    close_out();
  end
endmodule
